// *** pkg/pmr_pkg.sv ***
// Function
// (RULE_01) Match sets flag bit 7.
// (RULE_02) Writing one clears flag and request.
// (RULE_03) Enable bit 6 gates match interrupt.
// (RULE_04) Interrupt enable readable, writable, reset zero.
// (RULE_05) Output enable bit 4 toggles pin.
// (RULE_06) Reserved bits read zero, ignore writes.
// (RULE_07) Source select picks oscillator, low-power, bus.
// (RULE_08) Source change clears divider and counter.
// (RULE_09) Divider change clears divider and counter.
// (RULE_10) Divider code zero stops; reset zero.
// (RULE_11) Even source: divide 1 to 64.
// (RULE_12) Odd source: 128 to 2048, 100, 1000.
// (RULE_13) Sixteen-bit limit; match wraps count to zero.
// (RULE_14) Zero limit flags every prescaler pulse.
// (RULE_15) Low byte read locks high byte.
// (RULE_16) New limit latched until overflow or start.
// (RULE_17) Toggle pin high after reset.
// (RULE_18) Counter advances once per prescaler pulse.
package pmr_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [13:0] IDX_STATUS_CONTROL = 14'h306a;
	localparam logic [13:0] IDX_PRESCALE_SELECT = 14'h306b;
	localparam logic [13:0] IDX_LIMIT_HIGH = 14'h306c;
	localparam logic [13:0] IDX_LIMIT_LOW = 14'h306d;
	localparam logic [13:0] IDX_COUNT_HIGH = 14'h306e;
	localparam logic [13:0] IDX_COUNT_LOW = 14'h306f;
	localparam logic [13:0] IDX_EVENT_STATUS = 14'h3070;
	localparam logic [13:0] IDX_EVENT_MASK = 14'h3071;
	localparam int ADDR_W = 16;

	// Field positions.
	localparam int BIT_MATCH_FLAG = 7;
	localparam int BIT_IRQ_ENABLE = 6;
	localparam int BIT_TOGGLE_ENABLE = 4;
	localparam int SRC_HI = 7;
	localparam int SRC_LO = 6;
	localparam int DIV_HI = 2;
	localparam int DIV_LO = 0;
	localparam int EVT_MATCH = 0;
	localparam int EVT_TOGGLE = 1;

	// Reset values.
	localparam logic [1:0] SRC_RESET = 2'h0;
	localparam logic [2:0] DIV_RESET = 3'h0;
	localparam logic [15:0] LIMIT_RESET = 16'h0000;
	localparam logic [1:0] EVT_RESET = 2'h0;

	// Source select codes.
	localparam logic [1:0] SRC_EXT_OSC = 2'h0;
	localparam logic [1:0] SRC_LOW_POWER = 2'h1;

	// Divide ratios per code, binary and decimal sets.
	localparam int DIV_W = 11;
	localparam logic [10:0] DIV_BIN [0:7] = '{11'h001, 11'h001, 11'h002, 11'h004,
		11'h008, 11'h010, 11'h020, 11'h040};
	localparam logic [10:0] DIV_ALT [0:7] = '{11'h001, 11'h080, 11'h100, 11'h200,
		11'h400, 11'h7ff, 11'h064, 11'h3e8};

	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** pkg/pmr_tick_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Clear from the control logic to the prescaler and match counter, and tick from the prescaler to the match counter.
interface pmr_tick_if;
	logic clear;
	logic tick;
	modport ctrl (output clear);
	modport presc (input clear, output tick);
	modport cnt (input clear, input tick);
endinterface
`default_nettype wire

// *** src/pmr_match_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
module pmr_match_counter (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Link from the prescaler.
	pmr_tick_if.cnt tk,
	// Limit staging.
	input wire logic [15:0] limit_stage,
	input wire logic load_req,
	// Count and match.
	output logic [15:0] count,
	output logic match
);
	logic [15:0] limit_eff;

	// Up-count that wraps at the active limit.
	always_ff @(posedge clock) begin
		if (rst || tk.clear) begin // RULE_08 RULE_09
			count <= 16'h0000;
			match <= 1'b0;
		end else begin
			match <= 1'b0;
			if (tk.tick) begin // RULE_18
				if (count == limit_eff) begin // RULE_13 RULE_14
					count <= 16'h0000;
					match <= 1'b1;
				end else begin
					count <= count + 16'h0001;
				end
			end
		end
	end

	// The active limit changes only at a wrap or a start, so a half-written limit acts only if a wrap or a start falls between its two byte writes.
	always_ff @(posedge clock) begin
		if (rst) begin
			limit_eff <= pmr_pkg::LIMIT_RESET;
		end else if (load_req || (tk.tick && count == limit_eff)) begin // RULE_16
			limit_eff <= limit_stage;
		end
	end
endmodule // pmr_match_counter
`default_nettype wire

// *** src/pmr_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
module pmr_prescaler #(
	parameter int DIV_W = 11
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Source edges and selection.
	input wire logic src_tick,
	input wire logic src_odd,
	input wire logic [2:0] div_sel,
	// Link to the counter.
	pmr_tick_if.presc tk
);
	logic [DIV_W-1:0] div_cnt;
	logic [DIV_W-1:0] ratio;

	if (DIV_W < 11) begin : g_width_check
		$error("Prescaler width too small for 2048.");
	end

	// Ratio lookup; 2048 is stored as 2047 plus one below.
	always_comb begin
		ratio = src_odd ? DIV_W'(pmr_pkg::DIV_ALT[div_sel]) : DIV_W'(pmr_pkg::DIV_BIN[div_sel]); // RULE_11 RULE_12
		if (src_odd && div_sel == 3'h5) begin
			ratio = DIV_W'(12'h800);
		end
	end

	// Divider count; a zero code holds it idle.
	always_ff @(posedge clock) begin
		if (rst || tk.clear || div_sel == 3'h0) begin // RULE_08 RULE_09 RULE_10
			div_cnt <= '0;
			tk.tick <= 1'b0;
		end else begin
			tk.tick <= 1'b0;
			if (src_tick) begin
				if (div_cnt == ratio - DIV_W'(1)) begin
					div_cnt <= '0;
					tk.tick <= 1'b1;
				end else begin
					div_cnt <= div_cnt + DIV_W'(1);
				end
			end
		end
	end
endmodule // pmr_prescaler
`default_nettype wire

// *** src/pmr_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module pmr_top (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// AXI4-Lite write address.
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// AXI4-Lite write data.
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response.
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address.
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// AXI4-Lite read data.
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Clock sources from pins.
	input wire logic ext_osc,
	input wire logic low_power_osc,
	// Outputs.
	output logic toggle_out,
	output logic irq
);
	// Write channel holding state.
	logic aw_full;
	logic w_full;
	logic [13:0] aw_idx;
	logic [7:0] w_byte;
	logic w_lane0;
	logic wr_go;
	logic wr_hit;
	// Read decode.
	logic [13:0] ar_idx;
	logic [7:0] rd_byte;
	logic rd_hit;
	// Registers.
	logic match_flag;
	logic match_irq_enable;
	logic toggle_output_enable;
	logic [1:0] source_select;
	logic [2:0] divider_select;
	logic [7:0] limit_high;
	logic [7:0] limit_low;
	logic [7:0] count_high_lock;
	logic [1:0] evt_status;
	logic [1:0] evt_mask;
	// Counter side.
	logic clear_pulse;
	logic load_pulse;
	logic [15:0] tick_count;
	logic match;
	logic src_tick;
	// Pin synchronisers, one lane each for oscillator and low-power source.
	logic [1:0] pin_in;
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] sync3;
	logic [1:0] pin_level;
	logic [1:0] pin_rise;
	// Write strobes per register.
	logic wr_sc1;
	logic wr_sc2;
	logic wr_limh;
	logic wr_liml;
	logic wr_evt;
	logic wr_mask;

	pmr_tick_if tk ();

	assign pin_in = {low_power_osc, ext_osc};

	// Three stages per pin; the filtered level moves only when stages two and three agree.
	for (genvar i = 0; i < 2; i++) begin : g_pin
		always_ff @(posedge clock) begin
			if (rst) begin
				sync1[i] <= 1'b0;
				sync2[i] <= 1'b0;
				sync3[i] <= 1'b0;
				pin_level[i] <= 1'b0;
				pin_rise[i] <= 1'b0;
			end else begin
				sync1[i] <= pin_in[i];
				sync2[i] <= sync1[i];
				sync3[i] <= sync2[i];
				if (sync2[i] == sync3[i]) begin
					pin_level[i] <= sync3[i];
				end
				pin_rise[i] <= (sync2[i] == sync3[i]) && sync3[i] && !pin_level[i];
			end
		end
	end

	// Source routing; both upper codes pick the bus clock, which ticks every cycle.
	always_comb begin
		case (source_select)
			pmr_pkg::SRC_EXT_OSC: src_tick = pin_rise[0]; // RULE_07
			pmr_pkg::SRC_LOW_POWER: src_tick = pin_rise[1];
			default: src_tick = 1'b1;
		endcase
	end

	assign tk.clear = clear_pulse;

	pmr_prescaler #(
		.DIV_W(pmr_pkg::DIV_W)
	) u_presc (
		.clock(clock),
		.rst(rst),
		.src_tick(src_tick),
		.src_odd(source_select[0]),
		.div_sel(divider_select),
		.tk(tk.presc)
	);

	pmr_match_counter u_cnt (
		.clock(clock),
		.rst(rst),
		.tk(tk.cnt),
		.limit_stage({limit_high, limit_low}),
		.load_req(load_pulse),
		.count(tick_count),
		.match(match)
	);

	// Write address and data are taken in either order and held until both are present.
	assign wr_go = aw_full && w_full && !s_axi_bvalid;
	assign wr_hit = (aw_idx >= pmr_pkg::IDX_STATUS_CONTROL) && (aw_idx <= pmr_pkg::IDX_EVENT_MASK);
	assign wr_sc1 = wr_go && w_lane0 && aw_idx == pmr_pkg::IDX_STATUS_CONTROL;
	assign wr_sc2 = wr_go && w_lane0 && aw_idx == pmr_pkg::IDX_PRESCALE_SELECT;
	assign wr_limh = wr_go && w_lane0 && aw_idx == pmr_pkg::IDX_LIMIT_HIGH;
	assign wr_liml = wr_go && w_lane0 && aw_idx == pmr_pkg::IDX_LIMIT_LOW;
	assign wr_evt = wr_go && w_lane0 && aw_idx == pmr_pkg::IDX_EVENT_STATUS;
	assign wr_mask = wr_go && w_lane0 && aw_idx == pmr_pkg::IDX_EVENT_MASK;

	// Write channel handshakes and response.
	always_ff @(posedge clock) begin
		if (rst) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_idx <= 14'h0000;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= pmr_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_idx <= s_axi_awaddr[15:2];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? pmr_pkg::RESP_OKAY : pmr_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Flag register; a match in the cycle of a clearing write keeps the flag set.
	always_ff @(posedge clock) begin
		if (rst) begin
			match_flag <= 1'b0; // RULE_02
		end else begin
			match_flag <= match || (match_flag && !(wr_sc1 && w_byte[pmr_pkg::BIT_MATCH_FLAG])); // RULE_01 RULE_02
		end
	end

	// Enable bits of the first control register.
	always_ff @(posedge clock) begin
		if (rst) begin
			match_irq_enable <= 1'b0; // RULE_04
			toggle_output_enable <= 1'b0;
		end else if (wr_sc1) begin
			match_irq_enable <= w_byte[pmr_pkg::BIT_IRQ_ENABLE]; // RULE_04
			toggle_output_enable <= w_byte[pmr_pkg::BIT_TOGGLE_ENABLE]; // RULE_05
		end
	end

	// Source and divider selection, with a clear pulse when either field really changes.
	always_ff @(posedge clock) begin
		if (rst) begin
			source_select <= pmr_pkg::SRC_RESET; // RULE_08
			divider_select <= pmr_pkg::DIV_RESET; // RULE_10
			clear_pulse <= 1'b0;
			load_pulse <= 1'b0;
		end else begin
			clear_pulse <= 1'b0;
			load_pulse <= 1'b0;
			if (wr_sc2) begin
				source_select <= w_byte[pmr_pkg::SRC_HI:pmr_pkg::SRC_LO];
				divider_select <= w_byte[pmr_pkg::DIV_HI:pmr_pkg::DIV_LO];
				clear_pulse <= (w_byte[pmr_pkg::SRC_HI:pmr_pkg::SRC_LO] != source_select) // RULE_08
					|| (w_byte[pmr_pkg::DIV_HI:pmr_pkg::DIV_LO] != divider_select); // RULE_09
				load_pulse <= w_byte[pmr_pkg::DIV_HI:pmr_pkg::DIV_LO] != 3'h0; // RULE_16
			end
		end
	end

	// Limit staging bytes; the counter adopts them later.
	always_ff @(posedge clock) begin
		if (rst) begin
			limit_high <= pmr_pkg::LIMIT_RESET[15:8]; // RULE_14
			limit_low <= pmr_pkg::LIMIT_RESET[7:0];
		end else begin
			if (wr_limh) begin
				limit_high <= w_byte; // RULE_13
			end
			if (wr_liml) begin
				limit_low <= w_byte;
			end
		end
	end

	// Event status and mask; the hardware set wins over a write-one clear.
	always_ff @(posedge clock) begin
		if (rst) begin
			evt_status <= pmr_pkg::EVT_RESET;
			evt_mask <= pmr_pkg::EVT_RESET;
		end else begin
			evt_status[pmr_pkg::EVT_MATCH] <= match
				|| (evt_status[pmr_pkg::EVT_MATCH] && !(wr_evt && w_byte[pmr_pkg::EVT_MATCH]));
			evt_status[pmr_pkg::EVT_TOGGLE] <= (match && toggle_output_enable)
				|| (evt_status[pmr_pkg::EVT_TOGGLE] && !(wr_evt && w_byte[pmr_pkg::EVT_TOGGLE]));
			if (wr_mask) begin
				evt_mask <= w_byte[1:0];
			end
		end
	end

	// Interrupt line, one cycle behind its causes so the pin comes from a flop.
	always_ff @(posedge clock) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= (match_flag && match_irq_enable) || |(evt_status & evt_mask); // RULE_03
		end
	end

	// Toggle pin starts high and flips on each wrap while enabled.
	always_ff @(posedge clock) begin
		if (rst) begin
			toggle_out <= 1'b1; // RULE_17
		end else if (match && toggle_output_enable) begin
			toggle_out <= !toggle_out; // RULE_05
		end
	end

	// Read decode; unused and reserved bits read as zero.
	assign ar_idx = s_axi_araddr[15:2];
	always_comb begin
		rd_hit = 1'b1;
		rd_byte = 8'h00;
		case (ar_idx)
			pmr_pkg::IDX_STATUS_CONTROL: begin
				rd_byte[pmr_pkg::BIT_MATCH_FLAG] = match_flag; // RULE_06
				rd_byte[pmr_pkg::BIT_IRQ_ENABLE] = match_irq_enable;
				rd_byte[pmr_pkg::BIT_TOGGLE_ENABLE] = toggle_output_enable;
			end
			pmr_pkg::IDX_PRESCALE_SELECT: begin
				rd_byte = {source_select, 3'h0, divider_select}; // RULE_06
			end
			pmr_pkg::IDX_LIMIT_HIGH: rd_byte = limit_high;
			pmr_pkg::IDX_LIMIT_LOW: rd_byte = limit_low;
			pmr_pkg::IDX_COUNT_HIGH: rd_byte = count_high_lock; // RULE_15
			pmr_pkg::IDX_COUNT_LOW: rd_byte = tick_count[7:0];
			pmr_pkg::IDX_EVENT_STATUS: rd_byte = {6'h00, evt_status};
			pmr_pkg::IDX_EVENT_MASK: rd_byte = {6'h00, evt_mask};
			default: rd_hit = 1'b0;
		endcase
	end

	// Reading the low count byte freezes the high byte so a following read pairs with it.
	always_ff @(posedge clock) begin
		if (rst) begin
			count_high_lock <= 8'h00;
		end else if (s_axi_arvalid && s_axi_arready && ar_idx == pmr_pkg::IDX_COUNT_LOW) begin
			count_high_lock <= tick_count[15:8]; // RULE_15
		end
	end

	// Read channel; data are sampled at the address handshake.
	always_ff @(posedge clock) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= pmr_pkg::RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= rd_hit ? pmr_pkg::RESP_OKAY : pmr_pkg::RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // pmr_top
`default_nettype wire

// *** tb/pmr_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// Watches the register port and the two output pins of the match counter block.
module pmr_checker (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Register bus.
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	// Pins.
	input wire logic toggle_out,
	input wire logic irq
);
	logic [13:0] aw_idx;
	logic [13:0] rd_idx;
	logic [7:0] wd;
	logic ws;
	logic [7:0] sc1;
	logic [7:0] sc2;
	// Remembers each transfer's address and data until the response.
	always_ff @(posedge clock) begin
		if (rst) begin
			aw_idx <= '0;
			rd_idx <= '0;
			wd <= '0;
			ws <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) aw_idx <= s_axi_awaddr[15:2];
			if (s_axi_arvalid && s_axi_arready) rd_idx <= s_axi_araddr[15:2];
			if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
			if (s_axi_wvalid && s_axi_wready) ws <= s_axi_wstrb[0];
		end
	end
	// The shadow commits on the response, so it lags the design; the windows below allow for it.
	always_ff @(posedge clock) begin
		if (rst) begin
			sc1 <= '0;
			sc2 <= '0;
		end else if (s_axi_bvalid && s_axi_bready && ws) begin
			if (aw_idx == pmr_pkg::IDX_STATUS_CONTROL) sc1 <= wd;
			if (aw_idx == pmr_pkg::IDX_PRESCALE_SELECT) sc2 <= wd;
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence s_rd1;
		s_axi_rvalid && rd_idx == pmr_pkg::IDX_STATUS_CONTROL;
	endsequence
	sequence s_rd2;
		s_axi_rvalid && rd_idx == pmr_pkg::IDX_PRESCALE_SELECT;
	endsequence
	sequence s_pin_off;
		!sc1[4] [*4];
	endsequence
	sequence s_stopped;
		(sc2[2:0] == 3'h0) [*4];
	endsequence
	a_toggle_reset: assert property ($fell(rst) |-> toggle_out)
		else $error("Toggle pin low after reset.");
	a_irq_reset: assert property ($fell(rst) |-> !irq)
		else $error("Interrupt high after reset.");
	a_ctl_reserved: assert property (s_rd1 |-> s_axi_rdata[5] == 1'b0 && s_axi_rdata[3:0] == 4'h0)
		else $error("Reserved control bits read nonzero.");
	a_sel_reserved: assert property (s_rd2 |-> s_axi_rdata[5:3] == 3'h0)
		else $error("Reserved select bits read nonzero.");
	a_sel_readback: assert property (s_rd2 |-> s_axi_rdata[7:6] == sc2[7:6] && s_axi_rdata[2:0] == sc2[2:0])
		else $error("Select fields read back wrong.");
	a_ctl_readback: assert property (s_rd1 |-> s_axi_rdata[6] == sc1[6] && s_axi_rdata[4] == sc1[4])
		else $error("Enable bits read back wrong.");
	a_pin_gated: assert property (s_pin_off |-> $past(toggle_out, 2) == $past(toggle_out))
		else $error("Toggle pin moved while disabled.");
	a_stop_quiet: assert property (s_stopped |-> $past(toggle_out, 2) == $past(toggle_out))
		else $error("Toggle pin moved while stopped.");
endmodule // pmr_checker
bind pmr_top pmr_checker u_chk (.*);
`default_nettype wire

// *** tb/pmr_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module pmr_top_tb;
	logic clock, rst, ext_osc, low_power_osc, toggle_out, irq;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [1:0] wr_resp;
	localparam logic [13:0] R_CTL = pmr_pkg::IDX_STATUS_CONTROL;
	localparam logic [13:0] R_SEL = pmr_pkg::IDX_PRESCALE_SELECT;
	localparam logic [13:0] R_LIMH = pmr_pkg::IDX_LIMIT_HIGH;
	localparam logic [13:0] R_LIML = pmr_pkg::IDX_LIMIT_LOW;
	localparam int BIN [8] = '{0, 1, 2, 4, 8, 16, 32, 64};
	localparam int ALT [8] = '{0, 128, 256, 512, 1024, 2048, 100, 1000};
	pmr_top u_dut (.*);
	// Clock at 200 MHz.
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Slow pin sources of periods 20 and 14 cycles, and the hang guard.
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc % 10 == 9) ext_osc <= ~ext_osc;
		if (cyc % 7 == 6) low_power_osc <= ~low_power_osc;
		if (cyc == 80000) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Address and data go out together; each is dropped once taken.
	task automatic wr(input logic [13:0] idx, input logic [7:0] d);
		@(posedge clock);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h000000, d};
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		wr_resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [13:0] idx, output logic [7:0] d, output logic [1:0] r);
		@(posedge clock);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= {idx, 2'h0};
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata[7:0];
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [13:0] idx, input logic [7:0] e);
		logic [7:0] d;
		logic [1:0] r;
		rd(idx, d, r);
		`CHK(nm, e, d)
	endtask
	// Counts cycles until the toggle pin changes; the cap keeps a dead pin from hanging.
	task automatic wait_flip(output int n);
		logic t;
		t = toggle_out;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (toggle_out === t && n < 20000);
	endtask
	task automatic t_reset;
		logic [7:0] d;
		logic [1:0] r;
		rchk("ctl", R_CTL, 8'h00);
		rchk("sel", R_SEL, 8'h00);
		rchk("limh", R_LIMH, 8'h00);
		`CHK("pin", 1'b1, toggle_out)
		`CHK("irq", 1'b0, irq)
		rd(14'h3080, d, r);
		`CHK("rresp", pmr_pkg::RESP_SLVERR, r)
		`CHK("rdata", 8'h00, d)
		wr(14'h3080, 8'hff);
		`CHK("bresp", pmr_pkg::RESP_SLVERR, wr_resp)
	endtask
	task automatic t_regs;
		wr(R_CTL, 8'hff);
		`CHK("bresp", pmr_pkg::RESP_OKAY, wr_resp)
		rchk("ctl", R_CTL, 8'h50);
		wr(R_CTL, 8'h00);
		wr(R_LIMH, 8'hab);
		rchk("limh", R_LIMH, 8'hab);
		wr(R_LIMH, 8'h00);
		wr(R_SEL, 8'hff);
		rchk("sel", R_SEL, 8'hc7);
	endtask
	// Raise the flag, then gate and clear it with the counter stopped.
	task automatic t_irq;
		wr(R_LIML, 8'h03);
		wr(R_SEL, 8'h81);
		repeat (20) @(posedge clock);
		wr(R_SEL, 8'h80);
		rchk("flag", R_CTL, 8'h80);
		`CHK("irq", 1'b0, irq)
		wr(R_CTL, 8'h40);
		repeat (3) @(posedge clock);
		`CHK("irq", 1'b1, irq)
		wr(R_CTL, 8'h00);
		repeat (3) @(posedge clock);
		`CHK("irq", 1'b0, irq)
		rchk("flag", R_CTL, 8'h80);
		// Clearing with the enable set must also drop the request.
		wr(R_CTL, 8'hc0);
		repeat (3) @(posedge clock);
		`CHK("irq", 1'b0, irq)
		rchk("flag", R_CTL, 8'h40);
		wr(R_CTL, 8'h00);
		rchk("flag", R_CTL, 8'h00);
		// The event status and mask pair drive the same line.
		rchk("evt", pmr_pkg::IDX_EVENT_STATUS, 8'h01);
		wr(pmr_pkg::IDX_EVENT_MASK, 8'h01);
		repeat (3) @(posedge clock);
		`CHK("evt irq", 1'b1, irq)
		wr(pmr_pkg::IDX_EVENT_STATUS, 8'h01);
		repeat (3) @(posedge clock);
		`CHK("evt irq", 1'b0, irq)
		wr(pmr_pkg::IDX_EVENT_MASK, 8'h00);
	endtask
	// The count starts two cycles after the select write, so it reads 300 here.
	task automatic t_clear;
		wr(R_LIMH, 8'h03);
		wr(R_LIML, 8'hff);
		wr(R_SEL, 8'h81);
		repeat (300) @(posedge clock);
		rchk("cntl", pmr_pkg::IDX_COUNT_LOW, 8'h2c);
		repeat (300) @(posedge clock);
		rchk("cnth", pmr_pkg::IDX_COUNT_HIGH, 8'h01);
		wr(R_SEL, 8'hc1);
		rchk("cntl", pmr_pkg::IDX_COUNT_LOW, 8'h00);
		repeat (400) @(posedge clock);
		wr(R_SEL, 8'hc7);
		rchk("cntl", pmr_pkg::IDX_COUNT_LOW, 8'h00);
		rchk("cnth", pmr_pkg::IDX_COUNT_HIGH, 8'h00);
		wr(R_LIMH, 8'h00);
	endtask
	// Every source, and each nonzero code on the two bus sources; the third interval is measured so stale flips are skipped.
	task automatic t_rates;
		logic [1:0] src;
		logic [2:0] code;
		logic t;
		int lim, per, n;
		wr(R_CTL, 8'h10);
		for (int i = 0; i < 17; i++) begin
			src = (i < 7) ? 2'h2 : (i < 14) ? 2'h3 : (i == 14) ? 2'h0 : (i == 15) ? 2'h1 : 2'h2;
			code = (i < 7) ? 3'(i + 1) : (i < 14) ? 3'(i - 6) : 3'h1;
			lim = (i == 16) ? 0 : 1;
			per = (src == 2'h0) ? 20 : (src == 2'h1) ? 14 : 1;
			wr(R_LIML, 8'(lim));
			wr(R_SEL, {src, 3'h0, code});
			repeat (3) wait_flip(n);
			`CHK("interval", (lim + 1) * per * (src[0] ? ALT[code] : BIN[code]), n)
		end
		wr(R_CTL, 8'h00);
		t = toggle_out;
		repeat (64) @(posedge clock);
		`CHK("pin", t, toggle_out)
	endtask
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
		{s_axi_awprot, s_axi_arprot} = 6'h00;
		s_axi_wstrb = 4'hf;
		{ext_osc, low_power_osc} = 2'h0;
		rst = 1'b1;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_irq();
		t_clear();
		t_rates();
		print_verdict();
	end
endmodule // pmr_top_tb
`default_nettype wire
